// file: pkg/exec_pkg.sv
// Shared constants: instruction field layout, opcode codes, state encoding
package exec_pkg;
	localparam int DATA_W = 8;
	localparam int ADDR_W = 7;
	localparam int INSTR_W = 14;
	localparam int FILE_DEPTH = 128;
	// Field positions within the instruction word
	localparam int F_ADDR_LSB = 0;
	localparam int F_ADDR_MSB = 6;
	localparam int F_DEST_BIT = 7;
	localparam int F_BITSEL_LSB = 7;
	localparam int F_BITSEL_MSB = 9;
	localparam int F_LIT_LSB = 0;
	localparam int F_LIT_MSB = 7;
	localparam int F_OP6_LSB = 8;
	localparam int F_OP6_MSB = 13;
	localparam int F_OP4_LSB = 10;
	localparam int F_OP4_MSB = 13;
	// Opcodes
	localparam logic [5:0] add_file_op = 6'h07;
	localparam logic [5:0] and_file_op = 6'h05;
	localparam logic [5:0] add_immediate_op = 6'h3E;
	localparam logic [5:0] and_immediate_op = 6'h39;
	localparam logic [3:0] bit_clear_op = 4'h4;
	localparam logic [3:0] bit_set_op = 4'h5;
	localparam logic [3:0] test_skip_if_zero_op = 4'h6;
	// Destination select values
	localparam logic DEST_WORK = 1'b0;
	localparam logic DEST_FILE = 1'b1;
	// Reset values
	localparam logic [7:0] WORK_RESET = 8'h00;
	localparam logic FLAG_RESET = 1'b0;
	localparam logic [13:0] INSTR_RESET = 14'h0000;

	typedef enum logic [2:0] {
		ST_IDLE = 3'b001,
		ST_EXEC = 3'b010,
		ST_SKIP = 3'b100
	} exec_state_t;
endpackage : exec_pkg

// file: pkg/file_bus_if.sv
// Read and write port bundle between the core and the file register memory
interface file_bus_if;
	logic [6:0] rd_addr;
	logic [7:0] rd_data;
	logic wr_en;
	logic [6:0] wr_addr;
	logic [7:0] wr_data;

	modport ram (input rd_addr, output rd_data, input wr_en, input wr_addr, input wr_data);
	modport core (output rd_addr, input rd_data, output wr_en, output wr_addr, output wr_data);
endinterface : file_bus_if

// file: verilog/file_ram.sv
// File register memory, 128 x 8, registered read data
module file_ram
	import exec_pkg::*;
(
	input wire logic clk_sys,
	file_bus_if.ram bus
);
	logic [DATA_W-1:0] mem [FILE_DEPTH];
	logic [DATA_W-1:0] next_rd_data;

	always_comb begin
		next_rd_data = mem[bus.rd_addr];
	end

	always_ff @(posedge clk_sys) begin
		if (bus.wr_en) begin
			mem[bus.wr_addr] <= bus.wr_data;
		end
		bus.rd_data <= next_rd_data;
	end
endmodule : file_ram

// file: verilog/add_and_bit_op_execute.sv
// Execution core for add, AND, bit set, bit clear and bit-test-skip instructions
module add_and_bit_op_execute
	import exec_pkg::*;
(
	input wire logic clk_sys,
	input wire logic sys_rst,
	input wire logic instr_valid,
	input wire logic [13:0] instr,
	output logic instr_ready,
	output logic exec_done,
	output logic skip_done,
	output logic [7:0] work_reg,
	output logic carry_flag,
	output logic nibble_carry_flag,
	output logic zero_flag,
	input wire logic host_wr_en,
	input wire logic [6:0] host_addr,
	input wire logic [7:0] host_wr_data,
	output logic host_wr_ready,
	output logic [7:0] host_rd_data
);
	file_bus_if fbus ();

	file_ram u_file_ram (
		.clk_sys(clk_sys),
		.bus(fbus.ram)
	);

	// Sum with carry out of bit 7 and bit 3
	function automatic logic [9:0] add8(input logic [7:0] a, input logic [7:0] b);
		logic [8:0] full;
		logic [4:0] low;
		full = {1'b0, a} + {1'b0, b};
		low = {1'b0, a[3:0]} + {1'b0, b[3:0]};
		return {full[8], low[4], full[7:0]};
	endfunction : add8

	// Opcode field compares, one per field width
	function automatic logic match_op6(input logic [13:0] word, input logic [5:0] code);
		return word[F_OP6_MSB:F_OP6_LSB] == code;
	endfunction : match_op6

	function automatic logic match_op4(input logic [13:0] word, input logic [3:0] code);
		return word[F_OP4_MSB:F_OP4_LSB] == code;
	endfunction : match_op4

	exec_state_t state;
	exec_state_t next_state;
	// Held copy of the accepted word; the offer may change after the take edge
	logic [13:0] cur_instr;
	logic [13:0] next_cur_instr;
	logic [7:0] next_work_reg;
	logic next_carry;
	logic next_nibble;
	logic next_zero;
	logic next_exec_done;
	logic next_skip_done;

	logic take;
	logic is_add_imm;
	logic is_and_imm;
	logic is_add_file;
	logic is_and_file;
	logic is_bit_clear;
	logic is_bit_set;
	logic is_test_skip;
	logic [6:0] f_addr;
	logic [2:0] bit_sel;
	logic dest;
	logic [7:0] literal;
	logic [7:0] file_val;
	logic [9:0] sum_lit;
	logic [9:0] sum_file;
	logic [7:0] and_lit;
	logic [7:0] and_file;

	// At most one decode line is high; any other word runs as a no-op
	assign is_add_imm = match_op6(cur_instr, add_immediate_op);
	assign is_and_imm = match_op6(cur_instr, and_immediate_op);
	assign is_add_file = match_op6(cur_instr, add_file_op);
	assign is_and_file = match_op6(cur_instr, and_file_op);
	assign is_bit_clear = match_op4(cur_instr, bit_clear_op);
	assign is_bit_set = match_op4(cur_instr, bit_set_op);
	assign is_test_skip = match_op4(cur_instr, test_skip_if_zero_op);

	assign f_addr = cur_instr[F_ADDR_MSB:F_ADDR_LSB];
	assign bit_sel = cur_instr[F_BITSEL_MSB:F_BITSEL_LSB];
	assign dest = cur_instr[F_DEST_BIT];
	assign literal = cur_instr[F_LIT_MSB:F_LIT_LSB];
	assign file_val = fbus.rd_data;
	// Both operand paths are formed every cycle; the decode picks one
	assign sum_lit = add8(work_reg, literal);
	assign sum_file = add8(work_reg, file_val);
	assign and_lit = work_reg & literal;
	assign and_file = work_reg & file_val;

	assign instr_ready = (state == ST_IDLE) || (state == ST_SKIP);
	assign take = instr_valid && instr_ready;
	// Host writes only get the memory while the core is idle and not taking an instruction
	assign host_wr_ready = (state == ST_IDLE) && !instr_valid;
	assign host_rd_data = fbus.rd_data;

	// Memory read address: operand of the instruction being taken in IDLE, else the host address
	always_comb begin
		if (state == ST_IDLE && instr_valid) begin
			fbus.rd_addr = instr[F_ADDR_MSB:F_ADDR_LSB];
		end else begin
			fbus.rd_addr = host_addr;
		end
	end

	always_comb begin
		next_state = state;
		next_cur_instr = cur_instr;
		next_work_reg = work_reg;
		next_carry = carry_flag;
		next_nibble = nibble_carry_flag;
		next_zero = zero_flag;
		next_exec_done = 1'b0;
		next_skip_done = 1'b0;
		fbus.wr_en = 1'b0;
		fbus.wr_addr = host_addr;
		fbus.wr_data = host_wr_data;
		case (state)
			ST_IDLE: begin
				if (take) begin
					next_cur_instr = instr;
					next_state = ST_EXEC;
				end else if (host_wr_en) begin
					// Host writes win only while no instruction is offered
					fbus.wr_en = 1'b1;
				end
			end
			ST_EXEC: begin
				next_exec_done = 1'b1;
				next_state = ST_IDLE;
				// File write-back lands on the same edge that raises exec_done
				fbus.wr_addr = f_addr;
				if (is_add_imm) begin
					next_work_reg = sum_lit[7:0];
					next_carry = sum_lit[9];
					next_nibble = sum_lit[8];
					next_zero = (sum_lit[7:0] == 8'h00);
				end else if (is_and_imm) begin
					next_work_reg = and_lit;
					next_zero = (and_lit == 8'h00);
				end else if (is_add_file) begin
					next_carry = sum_file[9];
					next_nibble = sum_file[8];
					next_zero = (sum_file[7:0] == 8'h00);
					if (dest == DEST_FILE) begin
						fbus.wr_en = 1'b1;
						fbus.wr_data = sum_file[7:0];
					end else begin
						next_work_reg = sum_file[7:0];
					end
				end else if (is_and_file) begin
					next_zero = (and_file == 8'h00);
					if (dest == DEST_FILE) begin
						fbus.wr_en = 1'b1;
						fbus.wr_data = and_file;
					end else begin
						next_work_reg = and_file;
					end
				end else if (is_bit_clear) begin
					fbus.wr_en = 1'b1;
					fbus.wr_data = file_val & ~(8'h01 << bit_sel);
				end else if (is_bit_set) begin
					fbus.wr_en = 1'b1;
					fbus.wr_data = file_val | (8'h01 << bit_sel);
				end else if (is_test_skip) begin
					// Parking in SKIP turns the next accepted word into a no-op
					if (!file_val[bit_sel]) begin
						next_state = ST_SKIP;
					end
				end
			end
			ST_SKIP: begin
				// Next instruction is taken and thrown away, no state changes
				if (take) begin
					next_skip_done = 1'b1;
					next_state = ST_IDLE;
				end
			end
			default: begin
				next_state = ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			state <= ST_IDLE;
			cur_instr <= INSTR_RESET;
			work_reg <= WORK_RESET;
			carry_flag <= FLAG_RESET;
			nibble_carry_flag <= FLAG_RESET;
			zero_flag <= FLAG_RESET;
			exec_done <= 1'b0;
			skip_done <= 1'b0;
		end else begin
			state <= next_state;
			cur_instr <= next_cur_instr;
			work_reg <= next_work_reg;
			carry_flag <= next_carry;
			nibble_carry_flag <= next_nibble;
			zero_flag <= next_zero;
			exec_done <= next_exec_done;
			skip_done <= next_skip_done;
		end
	end
endmodule : add_and_bit_op_execute

// file: bench/exec_asserts.sv
// Port-level assertions for the execute core
module exec_asserts
	import exec_pkg::*;
(
	input wire logic clk_sys,
	input wire logic sys_rst,
	input wire logic instr_valid,
	input wire logic [13:0] instr,
	input wire logic instr_ready,
	input wire logic exec_done,
	input wire logic skip_done,
	input wire logic [7:0] work_reg,
	input wire logic carry_flag,
	input wire logic nibble_carry_flag,
	input wire logic zero_flag,
	input wire logic host_wr_ready
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking @(posedge clk_sys); endclocking
	default disable iff (sys_rst);
	a_state_hold: assert property (!$past(sys_rst) && !exec_done |->
		$stable({work_reg, carry_flag, nibble_carry_flag, zero_flag})) else $error("state moved without exec_done");
	a_take_done: assert property (instr_valid && instr_ready |-> ##[1:2] (exec_done || skip_done))
		else $error("taken instruction never completed");
	a_done_ready: assert property (exec_done |-> instr_ready) else $error("not ready after exec");
	a_done_pulse: assert property (exec_done |=> !exec_done) else $error("exec_done too long");
	a_add_imm: assert property (exec_done && $past(instr[13:8], 2) == add_immediate_op |->
		{carry_flag, work_reg} == {1'b0, $past(work_reg)} + {1'b0, $past(instr[7:0], 2)}) else $error("add sum wrong");
	a_and_imm: assert property (exec_done && $past(instr[13:8], 2) == and_immediate_op |->
		work_reg == ($past(work_reg) & $past(instr[7:0], 2)) && $stable(carry_flag)) else $error("and wrong");
	a_bit_flags: assert property (exec_done && $past(instr[13:12], 2) == 2'h1 |->
		$stable({work_reg, carry_flag, nibble_carry_flag, zero_flag})) else $error("bit op changed core state");
	a_zero_match: assert property (exec_done && $past(instr[13:8], 2) == add_immediate_op |->
		zero_flag == (work_reg == 8'h00)) else $error("zero flag wrong");
	a_host_gate: assert property (host_wr_ready |-> !instr_valid) else $error("host ready while instr offered");
endmodule : exec_asserts

bind add_and_bit_op_execute exec_asserts exec_asserts_i (.clk_sys, .sys_rst, .instr_valid, .instr, .instr_ready,
	.exec_done, .skip_done, .work_reg, .carry_flag, .nibble_carry_flag, .zero_flag, .host_wr_ready);

// file: bench/testbench.sv
// Self-checking bench for the execute core
module testbench
	import exec_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk_sys = 0, sys_rst = 1, instr_valid = 0, host_wr_en = 0, got_skip = 0;
	logic [13:0] instr = 14'h0000;
	logic [6:0] host_addr = 7'h00;
	logic [7:0] host_wr_data = 8'h00, work_reg, host_rd_data;
	logic instr_ready, exec_done, skip_done, carry_flag, nibble_carry_flag, zero_flag, host_wr_ready;
	int num_errors = 0, tests_run = 0;
	always #50 clk_sys = ~clk_sys;
	add_and_bit_op_execute add_and_bit_op_execute_i (.clk_sys, .sys_rst, .instr_valid, .instr, .instr_ready,
		.exec_done, .skip_done, .work_reg, .carry_flag, .nibble_carry_flag, .zero_flag, .host_wr_en, .host_addr,
		.host_wr_data, .host_wr_ready, .host_rd_data);
	task chk(input string n, input logic [10:0] s, input logic [10:0] e);
		tests_run++;
		if (s !== e) begin
			num_errors++;
			$display("Error %s expected %h seen %h", n, e, s);
		end
	endtask : chk
	// Flags above work register: carry, nibble carry, zero
	task chkw(input logic [10:0] e);
		chk("core", {carry_flag, nibble_carry_flag, zero_flag, work_reg}, e);
	endtask : chkw
	task issue(input logic [13:0] i);
		@(posedge clk_sys);
		instr_valid <= 1'b1;
		instr <= i;
		repeat (4) begin @(posedge clk_sys); if (instr_ready) break; end
		instr_valid <= 1'b0;
		repeat (4) begin @(posedge clk_sys); if (exec_done === 1'b1 || skip_done === 1'b1) break; end
		got_skip = skip_done;
		chk("done", {10'h000, exec_done | skip_done}, 11'h001);
	endtask : issue
	task hwr(input logic [6:0] a, input logic [7:0] d);
		@(posedge clk_sys);
		host_wr_en <= 1'b1;
		host_addr <= a;
		host_wr_data <= d;
		@(posedge clk_sys);
		host_wr_en <= 1'b0;
	endtask : hwr
	task hrd(input logic [6:0] a, input logic [7:0] e);
		@(posedge clk_sys);
		host_addr <= a;
		repeat (2) @(posedge clk_sys);
		chk("file", {3'h0, host_rd_data}, {3'h0, e});
	endtask : hrd
	task t_imm;
		issue(14'h3EFF);
		chkw(11'h0FF);
		issue(14'h3E3D);
		chkw(11'h63C);
		issue(14'h39C3);
		chkw(11'h700);
		issue(14'h3E81);
		chkw(11'h081);
		$display("test immediate finished");
	endtask : t_imm
	task t_file;
		hwr(7'h7F, 8'h0F);
		hwr(7'h10, 8'h6F);
		issue(14'h077F);
		chkw(11'h290);
		issue(14'h07FF);
		chkw(11'h090);
		hrd(7'h7F, 8'h9F);
		issue(14'h05FF);
		hrd(7'h7F, 8'h90);
		issue(14'h0510);
		chkw(11'h100);
		$display("test file finished");
	endtask : t_file
	task t_bits;
		hwr(7'h05, 8'h5A);
		issue(14'h1785);
		hrd(7'h05, 8'hDA);
		issue(14'h1085);
		hrd(7'h05, 8'hD8);
		chkw(11'h100);
		$display("test bits finished");
	endtask : t_bits
	task t_skip;
		issue(14'h1805);
		issue(14'h3E01);
		chk("skip", {10'h000, got_skip}, 11'h001);
		chkw(11'h100);
		issue(14'h1B85);
		issue(14'h3E01);
		chk("skip", {10'h000, got_skip}, 11'h000);
		chkw(11'h001);
		$display("test skip finished");
	endtask : t_skip
	task final_report;
		$display("checks %0d errors %0d", tests_run, num_errors);
		if (num_errors == 0 && tests_run > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask : final_report
	initial begin
		#200000;
		num_errors++;
		final_report;
	end
	initial begin
		repeat (6) @(posedge clk_sys);
		sys_rst <= 1'b0;
		chkw(11'h000);
		t_imm;
		t_file;
		t_bits;
		t_skip;
		final_report;
	end
endmodule : testbench
